// [src/iol_pkg.sv]
// constants for the increment / or / load-literal execute block
// assumes a 14-bit instruction word and an 8-bit accumulator and file bus
package iol_pkg;
  localparam int WORD_W = 14;
  localparam int DATA_W = 8;
  localparam int ADDR_W = 7;
  // opcode field positions
  localparam int OP6_HI = 13;
  localparam int OP6_LO = 8;
  localparam int OP4_HI = 13;
  localparam int OP4_LO = 10;
  localparam int DEST_BIT = 7;
  localparam logic [5:0] OPC_INCREMENT_FILE = 6'h0a;
  localparam logic [5:0] OPC_OR_ACCUM_FILE = 6'h04;
  localparam logic [5:0] OPC_OR_LITERAL = 6'h38;
  localparam logic [3:0] OPC_LOAD_LITERAL = 4'hc;
  localparam logic [DATA_W-1:0] ACCUM_RESET = 8'h00;
  localparam logic ZERO_RESET = 1'b0;
  localparam logic [DATA_W-1:0] ONE = 8'h01;
  typedef enum logic [4:0] {
    IOL_NONE = 5'b00001,
    IOL_INC = 5'b00010,
    IOL_ORL = 5'b00100,
    IOL_ORF = 5'b01000,
    IOL_MOVL = 5'b10000
  } iol_op_t;
endpackage

// [src/iol_decode.sv]
// instruction word decoder for the four executed opcodes
// assumes a valid 14-bit word on the same clock, purely combinational
`timescale 1ns/1ps
module iol_decode
  import iol_pkg::*;
(
  input wire logic [iol_pkg::WORD_W-1:0] word,
  output iol_pkg::iol_op_t op
);
  always_comb begin
    op = IOL_NONE;
    if (word[OP6_HI:OP6_LO] == OPC_INCREMENT_FILE) begin
      op = IOL_INC; // [RULE1]
    end else if (word[OP6_HI:OP6_LO] == OPC_OR_LITERAL) begin
      op = IOL_ORL; // [RULE3]
    end else if (word[OP6_HI:OP6_LO] == OPC_OR_ACCUM_FILE) begin
      op = IOL_ORF; // [RULE5]
    end else if (word[OP4_HI:OP4_LO] == OPC_LOAD_LITERAL) begin
      // bits 9:8 are ignored
      op = IOL_MOVL; // [RULE7]
    end
  end
endmodule

// [src/iol_exec.sv]
// execute stage for increment-file, or-literal, or-file and load-literal
// assumes the core presents one instruction per cycle with its file operand
// already read combinationally at FILE_ADDR; writes land one cycle later
// assertions at the end sample the registered answer one edge after the word
// How it works
// [RULE1] increment file, wrap, zero flag from result
// [RULE2] dest bit 0 to accumulator, 1 to file
// [RULE3] or literal low byte with accumulator
// [RULE4] or literal writes accumulator, updates zero
// [RULE5] or file, dest bit selects, updates zero
// [RULE6] load literal to accumulator, flags unchanged
// [RULE7] two bits above literal ignored
// [RULE8] one word, one cycle, no stall
`timescale 1ns/1ps
module iol_exec
  import iol_pkg::*;
(
  input wire logic CLOCK,
  input wire logic RESET_N,
  input wire logic INSTR_VALID,
  input wire logic [iol_pkg::WORD_W-1:0] INSTR_WORD,
  input wire logic [iol_pkg::DATA_W-1:0] FILE_RDATA,
  output logic [iol_pkg::ADDR_W-1:0] FILE_ADDR,
  output logic [iol_pkg::ADDR_W-1:0] FILE_WADDR_Q,
  output logic [iol_pkg::DATA_W-1:0] FILE_WDATA_Q,
  output logic FILE_WE_Q,
  output logic [iol_pkg::DATA_W-1:0] ACCUM_Q,
  output logic ZERO_Q,
  output logic DONE_Q
);
  iol_op_t op;
  logic [DATA_W-1:0] accum_d;
  logic zero_d;
  logic file_we_d;
  logic [DATA_W-1:0] file_wdata_d;
  logic [ADDR_W-1:0] file_waddr_d;
  logic done_d;
  logic [DATA_W-1:0] result;
  logic [DATA_W-1:0] literal;
  logic dest_file;

  iol_decode u_dec (
    .word(INSTR_WORD),
    .op(op)
  );

  // read address is driven combinationally so the operand arrives the same cycle
  assign FILE_ADDR = INSTR_WORD[ADDR_W-1:0];
  assign literal = INSTR_WORD[DATA_W-1:0];
  assign dest_file = INSTR_WORD[DEST_BIT];

  // one zero test shared by the three flag-updating operations
  function automatic logic zero_of(input logic [DATA_W-1:0] value);
    return value == 8'h00;
  endfunction

  always_comb begin
    accum_d = ACCUM_Q;
    zero_d = ZERO_Q;
    file_we_d = 1'b0;
    // the write port keeps its last address and data so an idle port does not toggle
    file_wdata_d = FILE_WDATA_Q;
    file_waddr_d = FILE_WADDR_Q;
    done_d = 1'b0;
    result = 8'h00;
    if (INSTR_VALID) begin
      done_d = (op != IOL_NONE); // [RULE8]
      unique case (op)
        IOL_INC: begin
          result = FILE_RDATA + ONE; // [RULE1]
          zero_d = zero_of(result); // [RULE1]
        end
        IOL_ORL: begin
          result = ACCUM_Q | literal; // [RULE3]
          accum_d = result; // [RULE4]
          zero_d = zero_of(result); // [RULE4]
        end
        IOL_ORF: begin
          result = ACCUM_Q | FILE_RDATA; // [RULE5]
          zero_d = zero_of(result); // [RULE5]
        end
        IOL_MOVL: begin
          accum_d = literal; // [RULE6]
        end
        IOL_NONE: begin
        end
      endcase
      // both file ops share the destination steering; the flag is set either way
      if (op == IOL_INC || op == IOL_ORF) begin
        if (dest_file) begin
          file_we_d = 1'b1; // [RULE2]
          file_wdata_d = result;
          file_waddr_d = INSTR_WORD[ADDR_W-1:0];
        end else begin
          accum_d = result; // [RULE2]
        end
      end
    end
  end

  always_ff @(posedge CLOCK or negedge RESET_N) begin
    if (!RESET_N) begin
      ACCUM_Q <= ACCUM_RESET;
      ZERO_Q <= ZERO_RESET;
      FILE_WE_Q <= 1'b0;
      FILE_WDATA_Q <= 8'h00;
      FILE_WADDR_Q <= 7'h00;
      DONE_Q <= 1'b0;
    end else begin
      ACCUM_Q <= accum_d;
      ZERO_Q <= zero_d;
      FILE_WE_Q <= file_we_d;
      FILE_WDATA_Q <= file_wdata_d;
      FILE_WADDR_Q <= file_waddr_d;
      DONE_Q <= done_d;
    end
  end

  default clocking cb @(posedge CLOCK); endclocking
  default disable iff (!RESET_N);

  // helpers decode the word apart from the decoder so a decode slip shows up
  wire is_inc = INSTR_VALID && INSTR_WORD[OP6_HI:OP6_LO] == OPC_INCREMENT_FILE;
  wire is_orl = INSTR_VALID && INSTR_WORD[OP6_HI:OP6_LO] == OPC_OR_LITERAL;
  wire is_orf = INSTR_VALID && INSTR_WORD[OP6_HI:OP6_LO] == OPC_OR_ACCUM_FILE;
  wire is_movl = INSTR_VALID && INSTR_WORD[OP4_HI:OP4_LO] == OPC_LOAD_LITERAL;
  wire any_op = is_inc || is_orl || is_orf || is_movl;
  wire to_file = (is_inc || is_orf) && INSTR_WORD[DEST_BIT];

  sequence inc_to_file_s;
    is_inc && INSTR_WORD[DEST_BIT];
  endsequence
  sequence inc_to_accum_s;
    is_inc && !INSTR_WORD[DEST_BIT];
  endsequence
  sequence orf_to_file_s;
    is_orf && INSTR_WORD[DEST_BIT];
  endsequence
  sequence orf_to_accum_s;
    is_orf && !INSTR_WORD[DEST_BIT];
  endsequence
  sequence movl_upper_set_s;
    is_movl && INSTR_WORD[OP6_LO+1:OP6_LO] != 2'h0;
  endsequence
  // each word is one step; the chained check spans two back-to-back words
  sequence inc_then_orl_s;
    inc_to_accum_s ##1 is_orl;
  endsequence
  sequence idle_s;
    !any_op;
  endsequence

  inc_wrap_a: assert property (is_inc && INSTR_WORD[7] |=> // [RULE1]
      FILE_WE_Q && FILE_WDATA_Q == $past(FILE_RDATA) + 8'h01
      && ZERO_Q == ($past(FILE_RDATA) == 8'hff))
    else $error("increment result or zero flag wrong");
  inc_to_accum_a: assert property (is_inc && !INSTR_WORD[7] |=> // [RULE2]
      !FILE_WE_Q && ACCUM_Q == $past(FILE_RDATA) + 8'h01)
    else $error("increment to accumulator wrong");
  orl_value_a: assert property (is_orl |=> // [RULE3]
      ACCUM_Q == ($past(ACCUM_Q) | $past(INSTR_WORD[7:0])) && !FILE_WE_Q)
    else $error("or literal value wrong");
  orl_zero_a: assert property (is_orl |=> ZERO_Q == (ACCUM_Q == 8'h00)) // [RULE4]
    else $error("or literal zero flag wrong");
  orf_dest_a: assert property (is_orf |=> // [RULE5]
      FILE_WE_Q == $past(INSTR_WORD[7])
      && ZERO_Q == (($past(ACCUM_Q) | $past(FILE_RDATA)) == 8'h00))
    else $error("or file result wrong");
  movl_flags_a: assert property (is_movl |=> // [RULE6]
      ACCUM_Q == $past(INSTR_WORD[7:0]) && $stable(ZERO_Q))
    else $error("load literal wrong");
  movl_dontcare_a: assert property (is_movl |-> op == IOL_MOVL) // [RULE7]
    else $error("load literal not decoded");
  one_cycle_a: assert property ((is_inc || is_orl || is_orf || is_movl) |=> DONE_Q) // [RULE8]
    else $error("instruction did not complete in one cycle");

  // increment zero flag, destination steering, write port contents, ignored literal bits and back-to-back chaining
  inc_zero_a: assert property (is_inc |=> // [RULE1]
      ZERO_Q == ($past(FILE_RDATA) == 8'hff))
    else $error("increment zero flag wrong");
  inc_file_a: assert property (inc_to_file_s |=> // [RULE2]
      FILE_WADDR_Q == $past(INSTR_WORD[ADDR_W-1:0]) && $stable(ACCUM_Q))
    else $error("increment write address or accumulator wrong");
  inc_accum_a: assert property (inc_to_accum_s |=> // [RULE2]
      $stable(FILE_WDATA_Q) && $stable(FILE_WADDR_Q))
    else $error("increment to accumulator touched the file write port");
  orf_accum_a: assert property (orf_to_accum_s |=> // [RULE5]
      ACCUM_Q == ($past(ACCUM_Q) | $past(FILE_RDATA)) && !FILE_WE_Q)
    else $error("or file to accumulator wrong");
  orf_file_a: assert property (orf_to_file_s |=> // [RULE5]
      FILE_WDATA_Q == ($past(ACCUM_Q) | $past(FILE_RDATA))
      && FILE_WADDR_Q == $past(INSTR_WORD[ADDR_W-1:0]) && $stable(ACCUM_Q))
    else $error("or file to register wrong");
  orl_keep_port_a: assert property (is_orl |=> // [RULE4]
      $stable(FILE_WDATA_Q) && $stable(FILE_WADDR_Q))
    else $error("or literal touched the file write port");
  movl_no_write_a: assert property (is_movl |=> // [RULE6]
      !FILE_WE_Q && $stable(FILE_WDATA_Q))
    else $error("load literal wrote the file");
  movl_upper_a: assert property (movl_upper_set_s |=> // [RULE7]
      ACCUM_Q == $past(INSTR_WORD[DATA_W-1:0]))
    else $error("load literal with upper bits set not executed");
  chain_no_stall_a: assert property (inc_then_orl_s |=> // [RULE8]
      ACCUM_Q == (($past(FILE_RDATA, 2) + 8'h01) | $past(INSTR_WORD[DATA_W-1:0])))
    else $error("back to back result not used in the next cycle");

  // refused words and gaps leave the accumulator and zero flag alone and raise no done or write pulse
  idle_quiet_a: assert property (idle_s |=> // [RULE8]
      !FILE_WE_Q && !DONE_Q && $stable(ACCUM_Q) && $stable(ZERO_Q))
    else $error("refused word changed state");
  done_source_a: assert property (DONE_Q |-> $past(any_op)) // [RULE8]
    else $error("completion pulse without an instruction");
  accum_source_a: assert property ($changed(ACCUM_Q) |-> // [RULE8]
      $past(any_op))
    else $error("accumulator moved without an instruction");
  write_source_a: assert property (FILE_WE_Q |-> $past(to_file) && DONE_Q) // [RULE2]
    else $error("file write without a file destination");
  wdata_hold_a: assert property ($changed(FILE_WDATA_Q) |-> FILE_WE_Q) // [RULE2]
    else $error("file write data moved without a write");
  waddr_hold_a: assert property ($changed(FILE_WADDR_Q) |-> FILE_WE_Q) // [RULE2]
    else $error("file write address moved without a write");
  zero_source_a: assert property ($changed(ZERO_Q) |-> // [RULE6]
      $past(is_inc || is_orl || is_orf))
    else $error("zero flag moved without a flag-updating instruction");
endmodule

// [sim/tb.sv]
// self-checking bench for the increment / or / load-literal execute block
// assumes iol_pkg and iol_exec are compiled first; inputs change on falling edges
`timescale 1ns/1ps
module tb;
  import iol_pkg::*;
  logic clock = 1'b0;
  logic reset_n = 1'b0;
  logic instr_valid = 1'b0;
  logic [WORD_W-1:0] instr_word = '0;
  logic [DATA_W-1:0] file_rdata = '0;
  logic [ADDR_W-1:0] file_addr;
  logic [ADDR_W-1:0] file_waddr_q;
  logic [DATA_W-1:0] file_wdata_q;
  logic [DATA_W-1:0] accum_q;
  logic file_we_q;
  logic zero_q;
  logic done_q;
  logic [DATA_W-1:0] acc = ACCUM_RESET;
  logic z = ZERO_RESET;
  logic [25:0] notes[$];
  int fails = 0;
  int checks_done = 0;

  always #10 clock = ~clock;

  iol_exec u_iol_exec (.CLOCK(clock), .RESET_N(reset_n), .INSTR_VALID(instr_valid),
    .INSTR_WORD(instr_word), .FILE_RDATA(file_rdata), .FILE_ADDR(file_addr),
    .FILE_WADDR_Q(file_waddr_q), .FILE_WDATA_Q(file_wdata_q), .FILE_WE_Q(file_we_q),
    .ACCUM_Q(accum_q), .ZERO_Q(zero_q), .DONE_Q(done_q));

  task automatic cmp_addr(input logic [ADDR_W-1:0] exp, input logic [ADDR_W-1:0] got);
    checks_done++;
    if (got !== exp) begin
      fails++;
      $display("[ERR] file_addr expected %h seen %h", exp, got);
    end
  endtask

  // packed as {done, write, write address, write data, accumulator, zero flag}
  task automatic cmp_exec(input logic [25:0] exp, input logic [25:0] got);
    checks_done++;
    if (got !== exp) begin
      fails++;
      $display("[ERR] result expected %h seen %h", exp, got);
    end
  endtask

  task automatic cmp_pending(input logic [31:0] exp, input logic [31:0] got);
    checks_done++;
    if (got !== exp) begin
      fails++;
      $display("[ERR] pending expected %0d seen %0d", exp, got);
    end
  endtask

  task automatic end_of_test();
    $display("checks %0d mismatches %0d", checks_done, fails);
    if (fails == 0 && checks_done > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask

  // model runs ahead by one edge; the note is taken when the block answers
  task automatic issue(input logic v, input logic [13:0] w, input logic [7:0] fd);
    logic [7:0] r;
    logic hit;
    logic we;
    @(negedge clock);
    instr_valid = v;
    instr_word = w;
    file_rdata = fd;
    hit = v;
    r = acc;
    if (w[13:8] == OPC_INCREMENT_FILE) r = fd + 8'h01;
    else if (w[13:8] == OPC_OR_ACCUM_FILE) r = acc | fd;
    else if (w[13:8] == OPC_OR_LITERAL) r = acc | w[7:0];
    else if (w[13:10] == OPC_LOAD_LITERAL) r = w[7:0];
    else hit = 1'b0;
    if (hit) begin
      if (w[13:10] != OPC_LOAD_LITERAL) z = (r == 8'h00);
      we = w[7] && (w[13:12] == 2'b00);
      if (!we) acc = r;
      notes.push_back({1'b1, we, we ? {w[6:0], r} : 15'h0000, acc, z});
    end
    #1 cmp_addr(w[ADDR_W-1:0], file_addr);
  endtask

  // every edge is checked, so a missing or extra pulse shows at once
  always @(posedge clock) begin
    #1;
    cmp_exec((notes.size() != 0) ? notes.pop_front() : {2'b00, 15'h0000, acc, z},
      {done_q, file_we_q, file_we_q ? {file_waddr_q, file_wdata_q} : 15'h0000,
       accum_q, zero_q});
  end

  initial begin
    int sel;
    logic [13:0] w;
    logic [7:0] k;
    logic [7:0] fd;
    void'($urandom(32'h0d38_fcb6));
    repeat (10) @(negedge clock);
    reset_n = 1'b1;
    issue(1'b1, {OPC_INCREMENT_FILE, 8'h85}, 8'hff);
    issue(1'b1, {OPC_OR_LITERAL, 8'h00}, 8'h5a);
    for (int i = 0; i < 600; i++) begin
      sel = $urandom % 6;
      k = ($urandom % 2) ? 8'($urandom) : {8{1'($urandom)}};
      fd = ($urandom % 2) ? 8'($urandom) : {8{1'($urandom)}};
      w = 14'($urandom);
      case (sel)
        0, 5: w[13:8] = OPC_INCREMENT_FILE;
        1: w = {OPC_OR_LITERAL, k};
        2: w[13:8] = OPC_OR_ACCUM_FILE;
        3: w = {OPC_LOAD_LITERAL, w[9:8], k};
        default: w[13:8] = 6'h0f;
      endcase
      issue(sel != 5, w, fd);
    end
    issue(1'b0, 14'h0000, 8'h00);
    repeat (2) @(negedge clock);
    cmp_pending(32'h0000_0000, 32'(notes.size()));
    end_of_test();
  end
endmodule
